// file: common/bridge_sideband_pkg.sv
// Summary of operation
// - both sideband requests low select guaranteed access, flush alone selects non-guaranteed mode, memory request alone selects an interrupt controller flush.
// - held posted writes drain whenever present; a sideband request waits until all have drained, the io bus request asserted except after a retry.
// - after a retry during the drain the io bus request is dropped as soon as the priority agent request is seen, not held until the drain ends.
// - before the memory grant is given, a retried posted write is reissued only after a fresh arbitration round on the priority agent request.
// - no inbound write is posted from the moment an outbound memory read, io read or io write leaves its queue until it has fully completed.
// - a retry of the final transfer of a multi-transfer outbound cycle does not end the posting block, only full completion does.
// - bit 6 of the bridge configuration register enables atomic read locking, which holds other pci masters off while a locked read is pending.
// - software can disable inbound write posting, so that inbound writes are refused rather than buffered.
package bridge_sideband_pkg;

	// ***********************************************************
	// register map
	// ***********************************************************
	localparam logic [7:0] CFG_OFFSET = 8'h4c;
	localparam logic [7:0] STATUS_OFFSET = 8'h50;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int CFG_POST_EN_BIT = 1;
	localparam int CFG_LOCK_BIT = 6;
	localparam int ST_DRAIN_BIT = 0;
	localparam int ST_GRANT_BIT = 1;
	localparam int ST_BLOCK_BIT = 2;
	localparam int ST_IOREQ_BIT = 3;
	localparam int ST_MODE_LSB = 4;
	localparam int ST_COUNT_LSB = 8;

	// ***********************************************************
	// pin synchroniser
	// ***********************************************************
	localparam logic [2:0] SYNC_RESET = 3'h7;

	// ***********************************************************
	// types
	// ***********************************************************
	typedef enum logic [1:0] {
		MODE_NONE,
		MODE_GUARANTEED,
		MODE_NON_GUARANTEED,
		MODE_INT_CTRL_FLUSH
	} sideband_mode_t;

	typedef enum logic [2:0] {
		DR_IDLE,
		DR_LOAD,
		DR_FETCH,
		DR_ISSUE,
		DR_BACKOFF,
		DR_REARB_LOW,
		DR_REARB_REQ
	} drain_state_t;

	// ***********************************************************
	// decode of the sideband request pair
	// ***********************************************************
	function automatic sideband_mode_t decode_mode(input logic flushReq,
		input logic memory_access_request);
		sideband_mode_t m;
		m = MODE_NONE;
		if (flushReq && memory_access_request) begin
			m = MODE_GUARANTEED;
		end else if (flushReq) begin
			m = MODE_NON_GUARANTEED;
		end else if (memory_access_request) begin
			m = MODE_INT_CTRL_FLUSH;
		end
		return m;
	endfunction

endpackage

// file: design/posted_write_store.sv
module posted_write_store #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 4,
	parameter int PTR_W = 2
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wrEn,
	input wire logic [PTR_W-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [PTR_W-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rdData;
	} store_t;

	store_t s;
	store_t n;

	// ***********************************************************
	// storage with registered read
	// ***********************************************************
	always_comb begin
		n = s;
		n.rdData = s.mem[rdAddr];
		if (wrEn) begin
			n.mem[wrAddr] = wrData;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign rdData = s.rdData;

endmodule

// file: design/bridge_sideband_flush_posting.sv
module bridge_sideband_flush_posting #(
	parameter int ADDR_W = 32,
	parameter int DATA_W = 32,
	parameter int DEPTH = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic flushBuffersRequestN,
	input wire logic memoryAccessRequestN,
	output logic memoryAccessGrantN,
	output logic [1:0] sidebandMode,
	input wire logic inWriteReq,
	input wire logic [ADDR_W-1:0] inWriteAddr,
	input wire logic [DATA_W-1:0] inWriteData,
	output logic inWritePosted,
	output logic inWriteRefused,
	input wire logic outboundStart,
	input wire logic outboundIsRead,
	input wire logic outboundComplete,
	output logic inboundBlocked,
	output logic lockAtomicReads,
	output logic pciLockHold,
	output logic ioBusRequestN,
	input wire logic priorityAgentRequestN,
	output logic hostWriteValid,
	output logic [ADDR_W-1:0] hostWriteAddr,
	output logic [DATA_W-1:0] hostWriteData,
	input wire logic hostWriteDone,
	input wire logic hostWriteRetry
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam int WORD_W = ADDR_W + DATA_W;
	localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

	typedef struct packed {
		logic [2:0] flushSync;
		logic [2:0] memSync;
		logic [2:0] priSync;
		logic flushFlt;
		logic memFlt;
		logic priFlt;
		bridge_sideband_pkg::sideband_mode_t mode;
		logic grantN;
		logic draining;
		logic [7:0] cfg;
		logic waitReq;
		logic [31:0] rdata;
		logic posted;
		logic refused;
		logic block;
		logic blockRead;
		logic lockHold;
		logic [PTR_W-1:0] head;
		logic [PTR_W-1:0] tail;
		logic [CNT_W-1:0] count;
		bridge_sideband_pkg::drain_state_t drain;
		logic ioReqN;
		logic hostValid;
		logic [ADDR_W-1:0] hostAddr;
		logic [DATA_W-1:0] hostData;
	} state_t;

	state_t s;
	state_t n;
	logic push;
	logic pop;
	logic [WORD_W-1:0] storeRd;

	// ***********************************************************
	// helpers
	// ***********************************************************
	function automatic logic reg_hit(input logic [7:0] a,
		input logic [7:0] off);
		return a == off;
	endfunction

	function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
		logic [PTR_W-1:0] r;
		r = (p == LAST_PTR) ? '0 : PTR_W'(p + 1'b1);
		return r;
	endfunction

	// ***********************************************************
	// posted write storage
	// ***********************************************************
	posted_write_store #(
		.WIDTH(WORD_W),
		.DEPTH(DEPTH),
		.PTR_W(PTR_W)
	) u_store (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wrEn(push),
		.wrAddr(s.tail),
		.wrData({inWriteAddr, inWriteData}),
		.rdAddr(s.head),
		.rdData(storeRd)
	);

	// ***********************************************************
	// next state
	// ***********************************************************
	always_comb begin
		logic sbActive;
		logic priOn;
		logic allow;
		logic reqOn;
		logic [31:0] rdWord;
		sbActive = 1'b0;
		priOn = 1'b0;
		allow = 1'b0;
		reqOn = 1'b0;
		rdWord = '0;
		n = s;
		push = 1'b0;
		pop = 1'b0;

		// pins pass three stages, a change counts when stages two and
		// three agree
		n.flushSync = {s.flushSync[1:0], flushBuffersRequestN};
		n.memSync = {s.memSync[1:0], memoryAccessRequestN};
		n.priSync = {s.priSync[1:0], priorityAgentRequestN};
		if (s.flushSync[1] == s.flushSync[2]) begin
			n.flushFlt = s.flushSync[2];
		end
		if (s.memSync[1] == s.memSync[2]) begin
			n.memFlt = s.memSync[2];
		end
		if (s.priSync[1] == s.priSync[2]) begin
			n.priFlt = s.priSync[2];
		end
		priOn = !s.priFlt;

		// sideband decode
		n.mode = bridge_sideband_pkg::decode_mode(!s.flushFlt,
			!s.memFlt);
		sbActive = s.mode != bridge_sideband_pkg::MODE_NONE;

		// outbound cycle block, a start wins over a completion
		n.block = outboundStart || (s.block && !outboundComplete);
		// a retried final transfer leaves the block standing
		if (outboundStart) begin
			n.blockRead = outboundIsRead;
		end
		n.lockHold = s.cfg[bridge_sideband_pkg::CFG_LOCK_BIT] && n.block
			&& n.blockRead;

		// inbound posting decision
		allow = s.cfg[bridge_sideband_pkg::CFG_POST_EN_BIT]
			&& !s.block && !outboundStart
			&& !sbActive && (s.count != FULL_COUNT);
		n.posted = 1'b0;
		n.refused = 1'b0;
		if (inWriteReq) begin
			if (allow) begin
				push = 1'b1;
				n.posted = 1'b1;
				n.tail = next_ptr(s.tail);
			end else begin
				n.refused = 1'b1;
			end
		end

		// drain toward the processor bus
		case (s.drain)
			bridge_sideband_pkg::DR_IDLE: begin
				if (s.count != '0) begin
					n.drain = bridge_sideband_pkg::DR_LOAD;
				end
			end
			bridge_sideband_pkg::DR_LOAD: begin
				n.drain = bridge_sideband_pkg::DR_FETCH;
			end
			bridge_sideband_pkg::DR_FETCH: begin
				if (priOn) begin
					n.drain = bridge_sideband_pkg::DR_ISSUE;
					n.hostValid = 1'b1;
					n.hostAddr = storeRd[WORD_W-1 -: ADDR_W];
					n.hostData = storeRd[DATA_W-1:0];
				end
			end
			bridge_sideband_pkg::DR_ISSUE: begin
				if (hostWriteDone) begin
					pop = 1'b1;
					n.hostValid = 1'b0;
					n.head = next_ptr(s.head);
					n.drain = bridge_sideband_pkg::DR_IDLE;
				end else if (hostWriteRetry) begin
					n.hostValid = 1'b0;
					n.drain = bridge_sideband_pkg::DR_BACKOFF;
				end
			end
			bridge_sideband_pkg::DR_BACKOFF: begin
				if (priOn) begin
					n.drain = bridge_sideband_pkg::DR_REARB_LOW;
				end
			end
			bridge_sideband_pkg::DR_REARB_LOW: begin
				if (!priOn) begin
					n.drain = bridge_sideband_pkg::DR_REARB_REQ;
				end
			end
			bridge_sideband_pkg::DR_REARB_REQ: begin
				if (priOn) begin
					n.drain = bridge_sideband_pkg::DR_ISSUE;
					n.hostValid = 1'b1;
				end
			end
			default: begin
				n.drain = bridge_sideband_pkg::DR_IDLE;
				n.hostValid = 1'b0;
			end
		endcase

		// occupancy
		case ({push, pop})
			2'b10: n.count = CNT_W'(s.count + 1'b1);
			2'b01: n.count = CNT_W'(s.count - 1'b1);
			default: n.count = s.count;
		endcase

		// io bus request held across the drain, dropped after a retry
		case (n.drain)
			bridge_sideband_pkg::DR_LOAD,
			bridge_sideband_pkg::DR_FETCH,
			bridge_sideband_pkg::DR_ISSUE,
			bridge_sideband_pkg::DR_BACKOFF,
			bridge_sideband_pkg::DR_REARB_REQ: reqOn = 1'b1;
			bridge_sideband_pkg::DR_IDLE: reqOn = n.count != '0;
			default: reqOn = 1'b0;
		endcase
		n.ioReqN = !reqOn;

		// memory grant after the drain, held with the request
		n.draining = sbActive && ((n.count != '0)
			|| (n.drain != bridge_sideband_pkg::DR_IDLE));
		n.grantN = !(sbActive && (!s.grantN || !n.draining));

		// register bus, one wait cycle per access
		rdWord = '0;
		if (reg_hit(address, bridge_sideband_pkg::CFG_OFFSET)) begin
			rdWord[7:0] = s.cfg;
		end else if (reg_hit(address, bridge_sideband_pkg::STATUS_OFFSET))
			begin
			rdWord[bridge_sideband_pkg::ST_DRAIN_BIT] = s.draining;
			rdWord[bridge_sideband_pkg::ST_GRANT_BIT] = !s.grantN;
			rdWord[bridge_sideband_pkg::ST_BLOCK_BIT] = s.block;
			rdWord[bridge_sideband_pkg::ST_IOREQ_BIT] = !s.ioReqN;
			rdWord[bridge_sideband_pkg::ST_MODE_LSB +: 2] = s.mode;
			rdWord[bridge_sideband_pkg::ST_COUNT_LSB +: CNT_W] = s.count;
		end
		n.waitReq = 1'b1;
		if ((read || write) && s.waitReq) begin
			n.waitReq = 1'b0;
			n.rdata = rdWord;
		end
		if (write && !s.waitReq && byteenable[0]
			&& reg_hit(address, bridge_sideband_pkg::CFG_OFFSET)) begin
			n.cfg = writedata[7:0];
		end
	end

	// ***********************************************************
	// state register
	// ***********************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= '0;
			s.flushSync <= bridge_sideband_pkg::SYNC_RESET;
			s.memSync <= bridge_sideband_pkg::SYNC_RESET;
			s.priSync <= bridge_sideband_pkg::SYNC_RESET;
			s.flushFlt <= 1'b1;
			s.memFlt <= 1'b1;
			s.priFlt <= 1'b1;
			s.mode <= bridge_sideband_pkg::MODE_NONE;
			s.grantN <= 1'b1;
			s.cfg <= bridge_sideband_pkg::CFG_RESET;
			s.waitReq <= 1'b1;
			s.drain <= bridge_sideband_pkg::DR_IDLE;
			s.ioReqN <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ***********************************************************
	// outputs
	// ***********************************************************
	assign readdata = s.rdata;
	assign waitrequest = s.waitReq;
	assign memoryAccessGrantN = s.grantN;
	assign sidebandMode = s.mode;
	assign inWritePosted = s.posted;
	assign inWriteRefused = s.refused;
	assign inboundBlocked = s.block;
	assign lockAtomicReads = s.cfg[bridge_sideband_pkg::CFG_LOCK_BIT];
	assign pciLockHold = s.lockHold;
	assign ioBusRequestN = s.ioReqN;
	assign hostWriteValid = s.hostValid;
	assign hostWriteAddr = s.hostAddr;
	assign hostWriteData = s.hostData;

endmodule

// file: verification/bridge_sideband_monitor.sv
module bridge_sideband_monitor #(
	parameter int ADDR_W = 32
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	input wire logic memoryAccessGrantN,
	input wire logic [1:0] sidebandMode,
	input wire logic inWriteReq,
	input wire logic inWritePosted,
	input wire logic inWriteRefused,
	input wire logic outboundStart,
	input wire logic outboundComplete,
	input wire logic inboundBlocked,
	input wire logic lockAtomicReads,
	input wire logic pciLockHold,
	input wire logic ioBusRequestN,
	input wire logic priorityAgentRequestN,
	input wire logic hostWriteValid,
	input wire logic [ADDR_W-1:0] hostWriteAddr,
	input wire logic hostWriteDone,
	input wire logic hostWriteRetry
);
	timeunit 1ns;
	timeprecision 100ps;
	logic retryPend_q;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// ***********************************************************
	// retry pending until the io request is dropped
	// ***********************************************************
	always_ff @(posedge ref_clk) begin
		if (!rst_n || ioBusRequestN) begin
			retryPend_q <= 1'b0;
		end else if (hostWriteRetry) begin
			retryPend_q <= 1'b1;
		end
	end

	chk_bus_answer: assert property (
		(read || write) && waitrequest |=> !waitrequest)
		else $error("register access not answered");
	chk_post_answer: assert property (
		inWriteReq |=> inWritePosted != inWriteRefused)
		else $error("inbound write not answered once");
	chk_block_refuse: assert property (
		(inboundBlocked || outboundStart) && inWriteReq |=> inWriteRefused)
		else $error("write posted during outbound cycle");
	chk_block_stays: assert property (
		inboundBlocked && !outboundComplete |=> inboundBlocked)
		else $error("posting block ended early");
	chk_lock_hold: assert property (
		pciLockHold |-> lockAtomicReads && inboundBlocked)
		else $error("lock hold without cause");
	chk_mode_refuse: assert property (
		sidebandMode != 2'h0 && inWriteReq |=> inWriteRefused)
		else $error("write posted during sideband request");
	chk_valid_hold: assert property (
		hostWriteValid && !hostWriteDone && !hostWriteRetry
		|=> hostWriteValid && $stable(hostWriteAddr))
		else $error("host write dropped or changed");
	chk_retry_drop: assert property (
		(hostWriteRetry && !priorityAgentRequestN) ##1
		!priorityAgentRequestN [*7] |-> ioBusRequestN)
		else $error("io request held after retry");
	chk_reissue_rearb: assert property (
		$rose(hostWriteValid) |-> !retryPend_q)
		else $error("retried write reissued without rearbitration");
	chk_grant_drained: assert property (
		$fell(memoryAccessGrantN) |-> !hostWriteValid && sidebandMode != 2'h0)
		else $error("grant given before drain");
	chk_grant_release: assert property (
		!memoryAccessGrantN && sidebandMode == 2'h0 |=> memoryAccessGrantN)
		else $error("grant not released");
endmodule

bind bridge_sideband_flush_posting bridge_sideband_monitor #(
	.ADDR_W(ADDR_W)
) i_mon (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.read(read),
	.write(write),
	.waitrequest(waitrequest),
	.memoryAccessGrantN(memoryAccessGrantN),
	.sidebandMode(sidebandMode),
	.inWriteReq(inWriteReq),
	.inWritePosted(inWritePosted),
	.inWriteRefused(inWriteRefused),
	.outboundStart(outboundStart),
	.outboundComplete(outboundComplete),
	.inboundBlocked(inboundBlocked),
	.lockAtomicReads(lockAtomicReads),
	.pciLockHold(pciLockHold),
	.ioBusRequestN(ioBusRequestN),
	.priorityAgentRequestN(priorityAgentRequestN),
	.hostWriteValid(hostWriteValid),
	.hostWriteAddr(hostWriteAddr),
	.hostWriteDone(hostWriteDone),
	.hostWriteRetry(hostWriteRetry)
);

// file: verification/sideband_requester_model.sv
module sideband_requester_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] cmd,
	input wire logic memoryAccessGrantN,
	output logic flushBuffersRequestN,
	output logic memoryAccessRequestN
);
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic flushN;
		logic memN;
	} pins_t;
	pins_t s_q, s_d;

	// ***********************************************************
	// request pins, held until granted
	// ***********************************************************
	always_comb begin
		s_d.flushN = !cmd[1];
		s_d.memN = !cmd[0];
		if (cmd == 2'h0 && !(s_q.flushN && s_q.memN) && memoryAccessGrantN) begin
			s_d = s_q;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_q <= 2'h3;
		end else begin
			s_q <= s_d;
		end
	end
	assign flushBuffersRequestN = s_q.flushN;
	assign memoryAccessRequestN = s_q.memN;
endmodule

// file: verification/bridge_sideband_flush_posting_tb_top.sv
module bridge_sideband_flush_posting_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk, rst_n, read, write, waitrequest, inWriteReq, outboundStart;
	logic outboundIsRead, outboundComplete, flushBuffersRequestN, inWritePosted;
	logic memoryAccessRequestN, memoryAccessGrantN, inWriteRefused, hostWriteDone;
	logic inboundBlocked, lockAtomicReads, pciLockHold, ioBusRequestN;
	logic priorityAgentRequestN, hostWriteValid, hostWriteRetry;
	logic [7:0] address;
	logic [3:0] byteenable;
	logic [1:0] sidebandMode, cmd;
	logic [31:0] writedata, readdata, q, inWriteAddr, inWriteData;
	logic [31:0] hostWriteAddr, hostWriteData;
	logic [1:0] expMode [4];
	logic [31:0] expStatus;
	int failures, numChecks;

	bridge_sideband_flush_posting i_dut (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.byteenable(byteenable),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.flushBuffersRequestN(flushBuffersRequestN),
		.memoryAccessRequestN(memoryAccessRequestN),
		.memoryAccessGrantN(memoryAccessGrantN),
		.sidebandMode(sidebandMode),
		.inWriteReq(inWriteReq),
		.inWriteAddr(inWriteAddr),
		.inWriteData(inWriteData),
		.inWritePosted(inWritePosted),
		.inWriteRefused(inWriteRefused),
		.outboundStart(outboundStart),
		.outboundIsRead(outboundIsRead),
		.outboundComplete(outboundComplete),
		.inboundBlocked(inboundBlocked),
		.lockAtomicReads(lockAtomicReads),
		.pciLockHold(pciLockHold),
		.ioBusRequestN(ioBusRequestN),
		.priorityAgentRequestN(priorityAgentRequestN),
		.hostWriteValid(hostWriteValid),
		.hostWriteAddr(hostWriteAddr),
		.hostWriteData(hostWriteData),
		.hostWriteDone(hostWriteDone),
		.hostWriteRetry(hostWriteRetry)
	);
	sideband_requester_model i_req (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.cmd(cmd),
		.memoryAccessGrantN(memoryAccessGrantN),
		.flushBuffersRequestN(flushBuffersRequestN),
		.memoryAccessRequestN(memoryAccessRequestN)
	);

	// ***********************************************************
	// access tasks
	// ***********************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic busAccess(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 50) begin
			failures++;
			conclude();
		end
	endtask
	function automatic logic pick(input int sel);
		case (sel)
			0: return memoryAccessGrantN;
			1: return hostWriteValid;
			2: return ioBusRequestN;
			default: return sidebandMode != 2'h0;
		endcase
	endfunction
	task automatic waitFor(input int sel, input logic v);
		int n;
		n = 0;
		while (pick(sel) !== v && n < 100) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (n >= 100) begin
			failures++;
			conclude();
		end
	endtask
	task automatic post(input logic ok);
		@(posedge ref_clk);
		inWriteReq <= 1'b1;
		inWriteAddr <= inWriteAddr + 32'h4;
		inWriteData <= inWriteData + 32'h11;
		@(posedge ref_clk);
		inWriteReq <= 1'b0;
		#1;
		check(inWritePosted, ok);
		check(inWriteRefused, !ok);
	endtask
	task automatic strobe(input int sel);
		@(posedge ref_clk);
		hostWriteRetry <= sel == 0;
		hostWriteDone <= sel == 1;
		outboundComplete <= sel == 2;
		@(posedge ref_clk);
		hostWriteRetry <= 1'b0;
		hostWriteDone <= 1'b0;
		outboundComplete <= 1'b0;
		#1;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = !ref_clk;
	end

	initial begin
		{rst_n, read, write, inWriteReq, outboundStart, outboundIsRead} = 6'h0;
		{outboundComplete, hostWriteDone, hostWriteRetry, cmd} = 5'h0;
		{address, writedata, byteenable} = {8'h0, 32'h0, 4'hf};
		{inWriteAddr, inWriteData, priorityAgentRequestN} = {32'h1000, 32'h5a, 1'b1};
		{failures, numChecks} = {32'h0, 32'h0};
		expMode[0] = 2'h0;
		expMode[1] = bridge_sideband_pkg::MODE_INT_CTRL_FLUSH;
		expMode[2] = bridge_sideband_pkg::MODE_NON_GUARANTEED;
		expMode[3] = bridge_sideband_pkg::MODE_GUARANTEED;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		busAccess(1'b0, bridge_sideband_pkg::CFG_OFFSET, 32'h0);
		check(q, {24'h0, bridge_sideband_pkg::CFG_RESET});
		busAccess(1'b0, 8'h10, 32'h0);
		check(q, 32'h0);
		check(memoryAccessGrantN, 1'b1);
		post(1'b0);
		busAccess(1'b1, bridge_sideband_pkg::CFG_OFFSET, 32'h42);
		busAccess(1'b0, bridge_sideband_pkg::CFG_OFFSET, 32'h0);
		check(q, 32'h42);
		check(lockAtomicReads, 1'b1);
		byteenable <= 4'he;
		busAccess(1'b1, bridge_sideband_pkg::CFG_OFFSET, 32'h0);
		byteenable <= 4'hf;
		busAccess(1'b0, bridge_sideband_pkg::CFG_OFFSET, 32'h0);
		check(q, 32'h42);
		$display("test registers done");
		for (int i = 1; i < 4; i++) begin
			@(posedge ref_clk);
			cmd <= 2'(i);
			waitFor(3, 1'b1);
			check(sidebandMode, expMode[i]);
			waitFor(0, 1'b0);
			busAccess(1'b0, bridge_sideband_pkg::STATUS_OFFSET, 32'h0);
			expStatus = 32'(expMode[i]) << bridge_sideband_pkg::ST_MODE_LSB;
			expStatus[bridge_sideband_pkg::ST_GRANT_BIT] = 1'b1;
			check(q, expStatus);
			post(1'b0);
			@(posedge ref_clk);
			cmd <= 2'h0;
			waitFor(0, 1'b1);
		end
		$display("test sideband modes done");
		@(posedge ref_clk);
		outboundStart <= 1'b1;
		outboundIsRead <= 1'b1;
		@(posedge ref_clk);
		outboundStart <= 1'b0;
		#1;
		check(inboundBlocked, 1'b1);
		check(pciLockHold, 1'b1);
		repeat (3) post(1'b0);
		strobe(2);
		check(inboundBlocked, 1'b0);
		post(1'b1);
		check(ioBusRequestN, 1'b0);
		$display("test outbound block done");
		@(posedge ref_clk);
		cmd <= 2'h3;
		waitFor(3, 1'b1);
		repeat (4) @(posedge ref_clk);
		#1;
		check(memoryAccessGrantN, 1'b1);
		@(posedge ref_clk);
		priorityAgentRequestN <= 1'b0;
		waitFor(1, 1'b1);
		check(hostWriteAddr, inWriteAddr);
		check(hostWriteData, inWriteData);
		strobe(0);
		waitFor(2, 1'b1);
		check(hostWriteValid, 1'b0);
		repeat (8) @(posedge ref_clk);
		#1;
		check(ioBusRequestN, 1'b1);
		@(posedge ref_clk);
		priorityAgentRequestN <= 1'b1;
		waitFor(2, 1'b0);
		@(posedge ref_clk);
		priorityAgentRequestN <= 1'b0;
		waitFor(1, 1'b1);
		check(hostWriteAddr, inWriteAddr);
		strobe(1);
		waitFor(0, 1'b0);
		check(hostWriteValid, 1'b0);
		check(ioBusRequestN, 1'b1);
		@(posedge ref_clk);
		cmd <= 2'h0;
		waitFor(0, 1'b1);
		$display("test drain with retry done");
		conclude();
	end
endmodule
